// *** pfd_pkg.sv ***
// Constants, types and the default opcode table for the pass-through flag decoder.
// Assumes one APB clock domain; target phase events come from SCSI sequencer logic on the same clock.
// Function
// - Data-phase flag: 0 none, 1 data phase
// - Auto request sense unless inhibit flag set
// - Completion interrupt only when inhibit flag clear
// - Override flag selects flag byte over table
// - Direction 1 host-to-target, 0 target-to-host
// - Conflicting target phase ends with error 24H
// - Table used otherwise; undefined opcodes give none
// - Table entries for opcodes 00H to 1FH
// - Table entries for opcodes 20H to 3FH
// - Table entries for opcodes 40H to 5FH
// - No data means memory address fields ignored
// - Command identifier copied into completion status
package pfd_pkg;

	localparam int unsigned ADDR_W            = 12;
	localparam logic [11:0] ADDR_CMD_ID       = 12'h000;
	localparam logic [11:0] ADDR_CTRL         = 12'h004;
	localparam logic [11:0] ADDR_STATUS       = 12'h008;
	localparam logic [11:0] ADDR_DONE_ID      = 12'h00C;

	localparam int unsigned CTRL_OP_LSB       = 8;
	localparam int unsigned CTRL_START_BIT    = 16;

	localparam int unsigned STAT_BUSY_BIT     = 0;
	localparam int unsigned STAT_DONE_BIT     = 1;
	localparam int unsigned STAT_DAT_BIT      = 2;
	localparam int unsigned STAT_DIR_BIT      = 3;
	localparam int unsigned STAT_SENSE_BIT    = 4;
	localparam int unsigned STAT_ERR_LSB      = 8;
	localparam int unsigned STAT_SCSI_LSB     = 16;

	localparam int unsigned FLG_DAT_BIT       = 0;
	localparam int unsigned FLG_DIR_BIT       = 1;
	localparam int unsigned FLG_IRS_BIT       = 2;
	localparam int unsigned FLG_ICC_BIT       = 3;
	localparam int unsigned FLG_DBV_BIT       = 4;

	localparam logic [7:0]  ERR_NONE          = 8'h00;
	localparam logic [7:0]  ERR_UNEXP_PHASE   = 8'h24;
	localparam logic [7:0]  SCSI_CHECK_COND   = 8'h02;

	typedef enum logic [1:0] {
		PH_DATA_IN  = 2'b00,
		PH_DATA_OUT = 2'b01,
		PH_STATUS   = 2'b10,
		PH_OTHER    = 2'b11
	} pfd_phase_t;

	typedef enum logic [0:0] {
		ST_IDLE   = 1'b0,
		ST_ACTIVE = 1'b1
	} pfd_state_t;

	typedef struct packed {
		logic       strobe;
		pfd_phase_t phase;
		logic [7:0] status;
	} pfd_tgt_t;

	typedef struct packed {
		pfd_state_t  st;
		logic [31:0] cmd_id;
		logic [7:0]  opcode;
		logic        dat;
		logic        dir;
		logic        sense_inh;
		logic        irq_inh;
		logic        done;
		logic        sense_issued;
		logic [7:0]  err;
		logic [7:0]  scsi_status;
		logic [31:0] done_id;
		logic        irq;
		logic        sense_req;
		logic [31:0] prdata;
	} pfd_regs_t;

	// Returns {data phase expected, direction}.
	function automatic logic [1:0] pfd_default_flags(input logic [7:0] op);
		logic [1:0] r;
		r = 2'b00;
		case (op)
			8'h03, 8'h05, 8'h08, 8'h0F, 8'h12, 8'h14, 8'h1A, 8'h1C: r = 2'b10;
			8'h04, 8'h07, 8'h0A, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1D: r = 2'b11;
			8'h25, 8'h28, 8'h2C, 8'h2D, 8'h37, 8'h3C, 8'h3E:        r = 2'b10;
			8'h2A, 8'h2E, 8'h30, 8'h31, 8'h32, 8'h33:               r = 2'b11;
			8'h39, 8'h3A, 8'h3B, 8'h3F:                             r = 2'b11;
			8'h40, 8'h41, 8'h4C, 8'h55:                             r = 2'b11;
			8'h4D, 8'h5A:                                           r = 2'b10;
			default:                                                r = 2'b00;
		endcase
		return r;
	endfunction

endpackage

// *** pfd_decoder.sv ***
// APB-reached flag decoder for one pass-through command at a time.
// Assumes target phase events arrive as single-cycle strobes from sequencer logic on pclk.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module pfd_decoder #(
	parameter int unsigned P_DAT_BIT = pfd_pkg::FLG_DAT_BIT,
	parameter int unsigned P_DIR_BIT = pfd_pkg::FLG_DIR_BIT,
	parameter int unsigned P_IRS_BIT = pfd_pkg::FLG_IRS_BIT,
	parameter int unsigned P_ICC_BIT = pfd_pkg::FLG_ICC_BIT,
	parameter int unsigned P_DBV_BIT = pfd_pkg::FLG_DBV_BIT
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [pfd_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire pfd_pkg::pfd_tgt_t           tgt,
	output logic                             data_phase_expected,
	output logic                             xfer_dir,
	output logic                             mem_addr_use,
	output logic                             sense_req,
	output logic                             cmd_irq
);

	pfd_pkg::pfd_regs_t r_q;
	pfd_pkg::pfd_regs_t r_d;

	logic       wr_acc;
	logic       rd_setup;
	logic       mapped;
	logic       start;
	logic       finish;
	logic       bad_phase;
	logic       auto_sense;
	logic [7:0] wflags;
	logic [1:0] tbl;

	assign wr_acc   = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign mapped   = (paddr == pfd_pkg::ADDR_CMD_ID) || (paddr == pfd_pkg::ADDR_CTRL)
		|| (paddr == pfd_pkg::ADDR_STATUS) || (paddr == pfd_pkg::ADDR_DONE_ID);
	assign wflags   = pwdata[7:0];
	assign tbl      = pfd_pkg::pfd_default_flags(pwdata[pfd_pkg::CTRL_OP_LSB +: 8]);
	assign start    = wr_acc && (paddr == pfd_pkg::ADDR_CTRL) && pwdata[pfd_pkg::CTRL_START_BIT]
		&& (r_q.st == pfd_pkg::ST_IDLE);

	// A data phase the settings forbid, or one running the wrong way, is a conflict.
	always_comb
	begin
		bad_phase  = 1'b0;
		auto_sense = 1'b0;
		finish     = 1'b0;
		if (r_q.st == pfd_pkg::ST_ACTIVE && tgt.strobe)
		begin
			if (tgt.phase == pfd_pkg::PH_DATA_IN)
			begin
				bad_phase = !r_q.dat || r_q.dir;
			end
			else if (tgt.phase == pfd_pkg::PH_DATA_OUT)
			begin
				bad_phase = !r_q.dat || !r_q.dir;
			end
			else if (tgt.phase == pfd_pkg::PH_STATUS)
			begin
				finish     = 1'b1;
				auto_sense = (tgt.status == pfd_pkg::SCSI_CHECK_COND) && !r_q.sense_inh;
			end
			finish = finish || bad_phase;
		end
	end

	always_comb
	begin
		r_d           = r_q;
		r_d.irq       = 1'b0;
		r_d.sense_req = 1'b0;
		if (rd_setup)
		begin
			if (paddr == pfd_pkg::ADDR_CMD_ID)
			begin
				r_d.prdata = r_q.cmd_id;
			end
			else if (paddr == pfd_pkg::ADDR_CTRL)
			begin
				r_d.prdata = {16'h0000, r_q.opcode, 3'h0, r_q.dat, r_q.dir, r_q.sense_inh, r_q.irq_inh, 1'b0};
			end
			else if (paddr == pfd_pkg::ADDR_STATUS)
			begin
				r_d.prdata                                = 32'h0000_0000;
				r_d.prdata[pfd_pkg::STAT_BUSY_BIT]        = (r_q.st == pfd_pkg::ST_ACTIVE);
				r_d.prdata[pfd_pkg::STAT_DONE_BIT]        = r_q.done;
				r_d.prdata[pfd_pkg::STAT_DAT_BIT]         = r_q.dat;
				r_d.prdata[pfd_pkg::STAT_DIR_BIT]         = r_q.dir;
				r_d.prdata[pfd_pkg::STAT_SENSE_BIT]       = r_q.sense_issued;
				r_d.prdata[pfd_pkg::STAT_ERR_LSB +: 8]    = r_q.err;
				r_d.prdata[pfd_pkg::STAT_SCSI_LSB +: 8]   = r_q.scsi_status;
			end
			else if (paddr == pfd_pkg::ADDR_DONE_ID)
			begin
				r_d.prdata = r_q.done_id;
			end
			else
			begin
				r_d.prdata = 32'h0000_0000;
			end
		end
		if (wr_acc && paddr == pfd_pkg::ADDR_CMD_ID && r_q.st == pfd_pkg::ST_IDLE)
		begin
			r_d.cmd_id = pwdata;
		end
		if (start)
		begin
			r_d.st           = pfd_pkg::ST_ACTIVE;
			r_d.opcode       = pwdata[pfd_pkg::CTRL_OP_LSB +: 8];
			r_d.sense_inh    = wflags[P_IRS_BIT];
			r_d.irq_inh      = wflags[P_ICC_BIT];
			r_d.done         = 1'b0;
			r_d.sense_issued = 1'b0;
			r_d.err          = pfd_pkg::ERR_NONE;
			r_d.scsi_status  = 8'h00;
			if (wflags[P_DBV_BIT])
			begin
				r_d.dat = wflags[P_DAT_BIT];
				r_d.dir = wflags[P_DAT_BIT] && wflags[P_DIR_BIT];
			end
			else
			begin
				r_d.dat = tbl[1];
				r_d.dir = tbl[0];
			end
		end
		if (finish)
		begin
			r_d.st      = pfd_pkg::ST_IDLE;
			r_d.done    = 1'b1;
			r_d.done_id = r_q.cmd_id;
			r_d.irq     = !r_q.irq_inh;
			if (bad_phase)
			begin
				r_d.err = pfd_pkg::ERR_UNEXP_PHASE;
			end
			else
			begin
				r_d.scsi_status  = tgt.status;
				r_d.sense_req    = auto_sense;
				r_d.sense_issued = auto_sense;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_q <= '0;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign prdata              = r_q.prdata;
	assign pready              = 1'b1;
	assign pslverr             = psel && penable && !mapped;
	assign data_phase_expected = (r_q.st == pfd_pkg::ST_ACTIVE) && r_q.dat;
	assign xfer_dir            = r_q.dir;
	assign mem_addr_use        = (r_q.st == pfd_pkg::ST_ACTIVE) && r_q.dat;
	assign sense_req           = r_q.sense_req;
	assign cmd_irq             = r_q.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_irq_needs_enable;
		finish && r_q.irq_inh |=> !cmd_irq;
	endproperty
	a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("interrupt despite inhibit");

	property p_irq_on_finish;
		finish && !r_q.irq_inh |=> cmd_irq ##1 !cmd_irq;
	endproperty
	a_irq_on_finish: assert property (p_irq_on_finish) else $error("missing completion interrupt");

	property p_err_in;
		r_q.st == pfd_pkg::ST_ACTIVE && tgt.strobe && tgt.phase == pfd_pkg::PH_DATA_IN && !r_q.dat
			|=> r_q.err == pfd_pkg::ERR_UNEXP_PHASE && r_q.done && r_q.st == pfd_pkg::ST_IDLE;
	endproperty
	a_err_in: assert property (p_err_in) else $error("unexpected data-in not flagged");

	property p_err_dir;
		r_q.st == pfd_pkg::ST_ACTIVE && tgt.strobe && tgt.phase == pfd_pkg::PH_DATA_OUT && r_q.dat && !r_q.dir
			|=> r_q.err == pfd_pkg::ERR_UNEXP_PHASE;
	endproperty
	a_err_dir: assert property (p_err_dir) else $error("wrong direction not flagged");

	property p_auto_sense;
		r_q.st == pfd_pkg::ST_ACTIVE && tgt.strobe && tgt.phase == pfd_pkg::PH_STATUS
			&& tgt.status == pfd_pkg::SCSI_CHECK_COND && !r_q.sense_inh |=> sense_req && r_q.sense_issued;
	endproperty
	a_auto_sense: assert property (p_auto_sense) else $error("automatic sense not issued");

	property p_sense_inhibit;
		finish && r_q.sense_inh |=> !sense_req;
	endproperty
	a_sense_inhibit: assert property (p_sense_inhibit) else $error("sense issued despite inhibit");

	property p_id_copy;
		finish |=> r_q.done_id == $past(r_q.cmd_id);
	endproperty
	a_id_copy: assert property (p_id_copy) else $error("completion identifier mismatch");

	property p_override;
		start && wflags[P_DBV_BIT] |=> r_q.dat == $past(wflags[P_DAT_BIT]);
	endproperty
	a_override: assert property (p_override) else $error("override flag not honoured");

	property p_table;
		start && !wflags[P_DBV_BIT] |=> {r_q.dat, r_q.dir} == $past(tbl);
	endproperty
	a_table: assert property (p_table) else $error("table value not used");

	property p_no_data_no_addr;
		(r_q.st == pfd_pkg::ST_IDLE || !r_q.dat) |-> !mem_addr_use;
	endproperty
	a_no_data_no_addr: assert property (p_no_data_no_addr) else $error("address used without data");

	c_error_end: cover property (finish && bad_phase);
	c_auto_sense: cover property (finish && auto_sense);
	c_quiet_done: cover property (finish && r_q.irq_inh && !bad_phase);

endmodule // pfd_decoder

// *** pfd_target.sv ***
// Model of the SCSI target side: posts one-cycle phase events to the decoder.
// Assumes the sequencer clock is pclk; events may come at once or after a delay.
`timescale 1ns/1ps
module pfd_target (
	input  wire logic         pclk,
	output pfd_pkg::pfd_tgt_t tgt
);
	logic                on;
	pfd_pkg::pfd_phase_t ph;
	logic [7:0]          st;
	logic [9:0]          cnt;
	initial
	begin
		on = 1'b0;
		ph = pfd_pkg::PH_OTHER;
		st = 8'h00;
		cnt = 10'h000;
	end
	always @(posedge pclk) cnt <= cnt + 10'h001;
	// Outside an event the phase and status lines keep changing, so nothing stale can be mistaken for data.
	assign tgt = on ? {1'b1, ph, st} : {1'b0, cnt};
	task automatic send(input pfd_pkg::pfd_phase_t p, input logic [7:0] s, input int dly);
		repeat (dly) @(posedge pclk);
		@(posedge pclk);
		on <= 1'b1;
		ph <= p;
		st <= s;
		@(posedge pclk);
		on <= 1'b0;
	endtask
endmodule // pfd_target

// *** passthrough_flag_decoder_tb_top.sv ***
// Self-checking bench for the flag decoder: APB master tasks and one task per scenario.
// Assumes pready may stretch an access and target events come from pfd_target.
`timescale 1ns/1ps
module passthrough_flag_decoder_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, id = 32'h0;
	logic pready, pslverr, data_phase_expected, xfer_dir, mem_addr_use, sense_req, cmd_irq;
	pfd_pkg::pfd_tgt_t tgt;
	int n_mismatch = 0, checks = 0;
	pfd_decoder pfd_decoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tgt(tgt), .data_phase_expected(data_phase_expected), .xfer_dir(xfer_dir),
		.mem_addr_use(mem_addr_use), .sense_req(sense_req), .cmd_irq(cmd_irq));
	pfd_target pfd_target_inst (.pclk(pclk), .tgt(tgt));
	initial forever #5 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [1:0] tbl(input logic [7:0] o);
		if (o inside {8'h03, 8'h05, 8'h08, 8'h0F, 8'h12, 8'h14, 8'h1A, 8'h1C, 8'h25, 8'h28, 8'h2C,
			8'h2D, 8'h37, 8'h3C, 8'h3E, 8'h4D, 8'h5A}) return 2'b10;
		if (o inside {8'h04, 8'h07, 8'h0A, [8'h15:8'h18], 8'h1D, 8'h2A, 8'h2E, [8'h30:8'h33],
			[8'h39:8'h3B], 8'h3F, 8'h40, 8'h41, 8'h4C, 8'h55}) return 2'b11;
		return 2'b00;
	endfunction
	function automatic logic [7:0] fl(input logic v, c, s, r, d);
		fl = 8'h00;
		fl[pfd_pkg::FLG_DBV_BIT] = v;
		fl[pfd_pkg::FLG_ICC_BIT] = c;
		fl[pfd_pkg::FLG_IRS_BIT] = s;
		fl[pfd_pkg::FLG_DIR_BIT] = r;
		fl[pfd_pkg::FLG_DAT_BIT] = d;
	endfunction
	// One command: post it, check the decode, feed target events, then check the outcome.
	task automatic run_cmd(input logic [7:0] op, f, input pfd_pkg::pfd_phase_t p, input logic [7:0] s,
		input logic xd, xr, input logic [7:0] xe);
		logic [31:0] r;
		logic e;
		logic se;
		id = id + 32'h0000_0101;
		se = s === pfd_pkg::SCSI_CHECK_COND && !f[pfd_pkg::FLG_IRS_BIT] && xe === 8'h00;
		apb(1'b1, pfd_pkg::ADDR_CMD_ID, id, r, e);
		apb(1'b1, pfd_pkg::ADDR_CTRL, {15'h0000, 1'b1, op, f}, r, e);
		#1;
		chk(data_phase_expected, xd);
		chk(xfer_dir, xr);
		chk(mem_addr_use, xd);
		apb(1'b0, pfd_pkg::ADDR_CTRL, 32'h0, r, e);
		chk(r, {16'h0000, op, 3'h0, xd, xr, f[pfd_pkg::FLG_IRS_BIT], f[pfd_pkg::FLG_ICC_BIT], 1'b0});
		pfd_target_inst.send(p, s, op[0] ? 3 : 0);
		if (xe === 8'h00 && p !== pfd_pkg::PH_STATUS)
			pfd_target_inst.send(pfd_pkg::PH_STATUS, s, 1);
		#1;
		chk(sense_req, se);
		chk(cmd_irq, !f[pfd_pkg::FLG_ICC_BIT]);
		apb(1'b0, pfd_pkg::ADDR_STATUS, 32'h0, r, e);
		chk(r[pfd_pkg::STAT_ERR_LSB +: 8], xe);
		chk(r[1:0], 32'h2);
		chk(r[4:2], {se, xr, xd});
		apb(1'b0, pfd_pkg::ADDR_DONE_ID, 32'h0, r, e);
		chk(r, id);
	endtask
	task automatic t_table;
		logic [1:0] x;
		for (int i = 0; i < 96; i++)
		begin
			x = tbl(8'(i));
			run_cmd(8'(i), 8'h00, pfd_pkg::PH_STATUS, 8'h00, x[1], x[0], 8'h00);
		end
	endtask
	// Reset in the middle of a command must drop it and clear every output except pready, which stays high.
	task automatic t_midreset;
		logic [31:0] r;
		logic e;
		apb(1'b1, pfd_pkg::ADDR_CTRL, {15'h0000, 1'b1, 8'h08, 8'h00}, r, e);
		#1;
		chk(data_phase_expected, 1'b1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		#1;
		chk({data_phase_expected, xfer_dir, mem_addr_use, sense_req, cmd_irq, pready}, 32'h1);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, pfd_pkg::ADDR_STATUS, 32'h0, r, e);
		chk(r, 32'h0);
	endtask
	task automatic t_override;
		run_cmd(8'h04, fl(1, 0, 0, 0, 0), pfd_pkg::PH_STATUS, 8'h00, 0, 0, 8'h00);
		run_cmd(8'h02, fl(1, 0, 0, 0, 1), pfd_pkg::PH_DATA_IN, 8'h00, 1, 0, 8'h00);
		run_cmd(8'h02, fl(1, 0, 0, 1, 1), pfd_pkg::PH_DATA_OUT, 8'h00, 1, 1, 8'h00);
		run_cmd(8'h02, fl(0, 0, 0, 1, 1), pfd_pkg::PH_STATUS, 8'h00, 0, 0, 8'h00);
	endtask
	task automatic t_sense_conflict;
		run_cmd(8'h00, fl(0, 0, 0, 0, 0), pfd_pkg::PH_STATUS, 8'h02, 0, 0, 8'h00);
		run_cmd(8'h00, fl(0, 1, 1, 0, 0), pfd_pkg::PH_STATUS, 8'h02, 0, 0, 8'h00);
		run_cmd(8'h08, 8'h00, pfd_pkg::PH_DATA_OUT, 8'h02, 1, 0, pfd_pkg::ERR_UNEXP_PHASE);
		run_cmd(8'h0A, 8'h00, pfd_pkg::PH_DATA_IN, 8'h00, 1, 1, pfd_pkg::ERR_UNEXP_PHASE);
		run_cmd(8'h01, fl(0, 1, 0, 0, 0), pfd_pkg::PH_DATA_IN, 8'h00, 0, 0, pfd_pkg::ERR_UNEXP_PHASE);
	endtask
	task automatic t_reset_unmapped;
		logic [31:0] r;
		logic e;
		chk({data_phase_expected, xfer_dir, mem_addr_use, sense_req, cmd_irq, pready}, 32'h1);
		apb(1'b0, pfd_pkg::ADDR_STATUS, 32'h0, r, e);
		chk(r, 32'h0);
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk(e, 32'h1);
		chk(r, 32'h0);
	endtask
	initial
	begin
		#100000;
		n_mismatch++;
		final_report;
	end
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_unmapped;
		t_table;
		t_override;
		t_sense_conflict;
		t_midreset;
		t_override;
		final_report;
	end
endmodule // passthrough_flag_decoder_tb_top
